// File: carrier_table.sv
// quadrature carrier lookup: cosine and sine of an eighth-turn phase.
// assumes the caller steps the phase once per accepted sample.
`timescale 1ns/10ps
module carrier_table
   import modulator_pkg::*;
(
   // phase in
   input wire logic [2:0] phase_i,
   // carrier out, q2.14
   output logic signed [15:0] cos_o,
   output logic signed [15:0] sin_o
);

   // ----------------------------------------------------------------
   // table
   // ----------------------------------------------------------------
   // one eighth-turn per phase step
   always_comb begin
      unique case (phase_i)
         3'h0: begin
            cos_o = CAR_ONE;
            sin_o = 16'sh0000;
         end
         3'h1: begin
            cos_o = CAR_RT2;
            sin_o = CAR_RT2;
         end
         3'h2: begin
            cos_o = 16'sh0000;
            sin_o = CAR_ONE;
         end
         3'h3: begin
            cos_o = -CAR_RT2;
            sin_o = CAR_RT2;
         end
         3'h4: begin
            cos_o = -CAR_ONE;
            sin_o = 16'sh0000;
         end
         3'h5: begin
            cos_o = -CAR_RT2;
            sin_o = -CAR_RT2;
         end
         3'h6: begin
            cos_o = 16'sh0000;
            sin_o = -CAR_ONE;
         end
         3'h7: begin
            cos_o = CAR_RT2;
            sin_o = -CAR_RT2;
         end
      endcase
   end

endmodule

// File: modulator_pkg.sv
// constants shared by the transmit back end: register map, control
// fields, carrier scaling and bus response codes.
// assumes a 32-bit axi4-lite register bus with 12 address bits.
package modulator_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;                          // bus address bits
   localparam logic [7:0] CTRL_INDEX = 8'h01;           // control word index
   localparam logic [7:0] STATUS_INDEX = 8'h02;         // status word index
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'b00, CTRL_INDEX, 2'b00};
   localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'b00, STATUS_INDEX, 2'b00};

   // ----------------------------------------------------------------
   // control word fields
   // ----------------------------------------------------------------
   localparam int CTRL_W = 8;                           // control word width
   localparam logic [7:0] CTRL_RESET = 8'h00;           // value after reset
   localparam int INTERP_LSB = 6;                       // interpolation code
   localparam int MOD_LSB = 4;                          // modulation rate code
   localparam int STUFF_BIT = 3;                        // zero stuffing enable
   localparam int CPLX_BIT = 2;                         // complex mix enable
   localparam int SIGN_BIT = 1;                         // negative carrier

   // ----------------------------------------------------------------
   // status word fields
   // ----------------------------------------------------------------
   localparam int RATIO_W = 5;                          // clock ratio width
   localparam int ST_CPLX_BIT = 8;                      // complex mix running
   localparam int ST_REFUSE_BIT = 9;                    // complex mix refused
   localparam int ST_PHASE_BIT = 10;                    // midscale pending

   // modulation rate, in field code order
   typedef enum logic [1:0] {
      MOD_NONE,
      MOD_HALF,
      MOD_QUARTER,
      MOD_EIGHTH
   } mod_rate_type;

   // ----------------------------------------------------------------
   // carrier scaling, q2.14
   // ----------------------------------------------------------------
   localparam int CAR_FRAC = 14;                        // fraction bits
   localparam logic signed [15:0] CAR_ONE = 16'sh4000;  // +1.0
   localparam logic signed [15:0] CAR_RT2 = 16'sh2D41;  // +0.7071
   localparam logic [2:0] STEP_HALF = 3'h4;             // phase step fdac/2
   localparam logic [2:0] STEP_QUARTER = 3'h2;          // phase step fdac/4
   localparam logic [2:0] STEP_EIGHTH = 3'h1;           // phase step fdac/8

   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: pair_buffer.sv
// small first-in first-out buffer in flip-flops with valid/ready on
// both sides. assumes the clock enable gates every transfer.
`timescale 1ns/10ps
module pair_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

   // refuse depths the pointer wrap cannot serve
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("pair_buffer depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];   // storage words
   logic [PW-1:0] wr_ptr;           // next slot to fill
   logic [PW-1:0] rd_ptr;           // oldest slot
   logic [PW:0] count;              // words held

   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i && ce_i;

   // honest full and empty
   assign in_ready_o = ce_i && (count != (PW + 1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   // ----------------------------------------------------------------
   // pointers and count
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

   // storage needs no reset
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule

// File: sample_source.sv
// partner model: the signal processor that feeds i/q pairs to the back end.
// assumes the bench sets the pair only while the stream is idle.
`timescale 1ns/10ps
module sample_source (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // control from the bench
   input wire logic go_i,
   input wire logic [15:0] i_set_i,
   input wire logic [15:0] q_set_i,
   // stream toward the block
   input wire logic ready_i,
   output logic valid_o,
   output logic [15:0] i_o,
   output logic [15:0] q_o,
   output int taken_o
);
   // valid holds until taken, then follows go; counts taken pairs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         taken_o <= 0;
      end else begin
         if (valid_o && ready_i) taken_o <= taken_o + 1;
         if (!valid_o || ready_i) valid_o <= go_i;
      end
   end
   // amplitudes reach full scale in one of the bench's pairs (7FFF and 8000)
   // idle lines show the inverse so a stale word is never mistaken for data
   assign i_o = valid_o ? i_set_i : ~i_set_i;
   assign q_o = valid_o ? q_set_i : ~q_set_i;
endmodule

// File: zero_stuff_complex_modulator.sv
// transmit back end: real or complex digital modulator, two-word
// buffer and optional midscale stuffing toward the dac cores.
// assumes filter-chain samples arrive twos complement on a valid/ready
// stream and the dac takes offset binary on a valid/ready stream.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module zero_stuff_complex_modulator
   import modulator_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int BUF_DEPTH = 2
) (
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // axi4-lite write address
   input wire logic [modulator_pkg::ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   // axi4-lite write data and response
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // axi4-lite read
   input wire logic [modulator_pkg::ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // filter-chain samples in
   input wire logic smp_valid_i,
   output logic smp_ready_o,
   input wire logic signed [SAMPLE_W-1:0] smp_i_i,
   input wire logic signed [SAMPLE_W-1:0] smp_q_i,
   // dac samples out
   output logic dac_valid_o,
   input wire logic dac_ready_i,
   output logic [SAMPLE_W-1:0] dac_real_o,
   output logic [SAMPLE_W-1:0] dac_imag_o,
   // clocking controls
   output logic [1:0] interp_sel_o,
   output logic [modulator_pkg::RATIO_W-1:0] clk_ratio_o
);

   import modulator_pkg::*;

   localparam int PW = SAMPLE_W + 16;     // product width
   localparam int SW = SAMPLE_W + 17;     // sum width

   // refuse sample widths the datapath cannot serve
   generate
      if (SAMPLE_W < 8 || SAMPLE_W > 24) begin : g_bad_width
         $error("sample width must lie between 8 and 24");
      end
   endgenerate

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // drop carrier fraction and clamp to the sample range
   function automatic logic signed [SAMPLE_W-1:0] clamp(input logic signed [SW-1:0] v);
      logic signed [SW-1:0] s;
      s = v >>> CAR_FRAC;
      if (s[SW-1:SAMPLE_W-1] != {(SW - SAMPLE_W + 1){s[SW-1]}}) begin
         clamp = s[SW-1] ? {1'b1, {(SAMPLE_W - 1){1'b0}}} : {1'b0, {(SAMPLE_W - 1){1'b1}}};
      end else begin
         clamp = s[SAMPLE_W-1:0];
      end
   endfunction

   // twos complement to offset binary
   function automatic logic [SAMPLE_W-1:0] to_dac(input logic [SAMPLE_W-1:0] v);
      to_dac = {~v[SAMPLE_W-1], v[SAMPLE_W-2:0]};
   endfunction

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl;               // control word
   logic aw_held;                         // write address captured
   logic [ADDR_W-1:0] aw_addr;            // captured write address
   logic w_held;                          // write data captured
   logic [31:0] w_data;                   // captured write data
   logic [3:0] w_strb;                    // captured byte enables

   // control decode
   mod_rate_type rate;
   wire stuff_en = ctrl[STUFF_BIT];
   wire cplx_req = ctrl[CPLX_BIT];
   wire sine_neg = ctrl[SIGN_BIT];
   assign rate = mod_rate_type'(ctrl[MOD_LSB+:2]);
   // complex mix cannot form quadrature at half rate
   wire cplx_active = cplx_req && (rate != MOD_HALF);
   wire cplx_refused = cplx_req && (rate == MOD_HALF);
   assign interp_sel_o = ctrl[INTERP_LSB+:2];
   // dac to data clock ratio, doubled while stuffing
   assign clk_ratio_o = RATIO_W'(1) <<
      ({1'b0, ctrl[INTERP_LSB+:2]} + {2'b00, stuff_en});

   // write decode
   wire do_write = aw_held && w_held && !bvalid_o;
   wire wr_ctrl_hit = (aw_addr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
   wire ctrl_wr = do_write && wr_ctrl_hit && w_strb[0];
   assign awready_o = ce_i && !aw_held && !bvalid_o;
   assign wready_o = ce_i && !w_held && !bvalid_o;
   assign arready_o = ce_i && !rvalid_o;

   // ----------------------------------------------------------------
   // axi4-lite write side
   // ----------------------------------------------------------------
   // capture address and data in either order, answer once both held
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid_o <= 1'b0;
         bresp_o <= RESP_OKAY;
      end else if (ce_i) begin
         if (awvalid_i && awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_held <= 1'b1;
            w_data <= wdata_i;
            w_strb <= wstrb_i;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o <= wr_ctrl_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   // control word; byte lane 0 carries every field
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= CTRL_RESET;
      end else if (ce_i && ctrl_wr) begin
         ctrl <= w_data[CTRL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read side
   // ----------------------------------------------------------------
   logic stuff_ph;                        // midscale owed next
   logic out_is_stuff;                    // output holds midscale
   wire rd_ctrl_hit = (araddr_i[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
   wire rd_stat_hit = (araddr_i[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);
   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[RATIO_W-1:0] = clk_ratio_o;
      status_word[ST_CPLX_BIT] = cplx_active;
      status_word[ST_REFUSE_BIT] = cplx_refused;
      status_word[ST_PHASE_BIT] = stuff_ph;
   end
   wire [31:0] rd_word = rd_ctrl_hit ? {24'h0000_00, ctrl} :
                         rd_stat_hit ? status_word : 32'h0000_0000;

   // answer one cycle after the address is taken
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rresp_o <= RESP_OKAY;
      end else if (ce_i) begin
         if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rdata_o <= rd_word;
            rresp_o <= (rd_ctrl_hit || rd_stat_hit) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // carrier
   // ----------------------------------------------------------------
   logic [2:0] phase;                     // carrier phase, eighth turns
   logic signed [15:0] cos_v;             // cosine term
   logic signed [15:0] sin_v;             // sine term
   carrier_table u_carrier (
      .phase_i(phase),
      .cos_o(cos_v),
      .sin_o(sin_v)
   );
   // step per modulation rate; no modulation holds phase 0
   wire [2:0] step = (rate == MOD_HALF) ? STEP_HALF :
                     (rate == MOD_QUARTER) ? STEP_QUARTER :
                     (rate == MOD_EIGHTH) ? STEP_EIGHTH : 3'h0;
   // sign of the complex exponential flips the sine term
   wire signed [15:0] sin_s = sine_neg ? -sin_v : sin_v;
   // real mode: cosine at half rate, sine at quarter and eighth
   wire signed [15:0] car_r = (rate == MOD_QUARTER || rate == MOD_EIGHTH) ? sin_v : cos_v;

   // ----------------------------------------------------------------
   // modulator datapath
   // ----------------------------------------------------------------
   logic mod_valid;                       // modulated pair held
   logic signed [SAMPLE_W-1:0] mod_re;    // real result
   logic signed [SAMPLE_W-1:0] mod_im;    // imaginary result
   logic buf_in_ready;                    // buffer has room
   wire mod_adv = !mod_valid || buf_in_ready;
   assign smp_ready_o = ce_i && mod_adv;
   wire smp_fire = smp_valid_i && smp_ready_o;

   wire signed [PW-1:0] p_ic = smp_i_i * cos_v;
   wire signed [PW-1:0] p_qs = smp_q_i * sin_s;
   wire signed [PW-1:0] p_is = smp_i_i * sin_s;
   wire signed [PW-1:0] p_qc = smp_q_i * cos_v;
   wire signed [PW-1:0] p_ir = smp_i_i * car_r;
   wire signed [PW-1:0] p_qr = smp_q_i * car_r;
   // complex product (i + jq)(cos + j sin); idle channel just gives zero terms
   wire signed [SW-1:0] sum_re = cplx_active ? (SW'(p_ic) - SW'(p_qs)) : SW'(p_ir);
   wire signed [SW-1:0] sum_im = cplx_active ? (SW'(p_is) + SW'(p_qc)) : SW'(p_qr);
   wire signed [SW-1:0] sh_re = sum_re >>> CAR_FRAC;

   // one register stage on unstuffed samples
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mod_valid <= 1'b0;
         mod_re <= '0;
         mod_im <= '0;
      end else if (ce_i && mod_adv) begin
         mod_valid <= smp_fire;
         if (smp_fire) begin
            mod_re <= clamp(sum_re);
            mod_im <= clamp(sum_im);
         end
      end
   end

   // phase moves once per accepted sample, restarts on a control write
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= 3'h0;
      end else if (ce_i) begin
         if (ctrl_wr) begin
            phase <= 3'h0;
         end else if (smp_fire) begin
            phase <= phase + step;
         end
      end
   end

   // ----------------------------------------------------------------
   // buffer
   // ----------------------------------------------------------------
   logic buf_valid;
   logic buf_pop;
   logic [2*SAMPLE_W-1:0] buf_data;
   pair_buffer #(
      .WIDTH(2 * SAMPLE_W),
      .DEPTH(BUF_DEPTH)
   ) u_buffer (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_valid_i(mod_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i({mod_re, mod_im}),
      .out_valid_o(buf_valid),
      .out_ready_i(buf_pop),
      .out_data_o(buf_data)
   );

   // ----------------------------------------------------------------
   // zero stuffing output stage
   // ----------------------------------------------------------------
   localparam logic [SAMPLE_W-1:0] MIDSCALE = {1'b1, {(SAMPLE_W - 1){1'b0}}};
   wire out_adv = ce_i && (!dac_valid_o || dac_ready_i);
   // a buffered word leaves only on a data slot
   assign buf_pop = out_adv && !stuff_ph;

   // data slot then, while enabled, a midscale slot on both channels
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_valid_o <= 1'b0;
         dac_real_o <= MIDSCALE;
         dac_imag_o <= MIDSCALE;
         stuff_ph <= 1'b0;
         out_is_stuff <= 1'b0;
      end else if (out_adv) begin
         if (stuff_ph) begin
            dac_valid_o <= 1'b1;
            dac_real_o <= MIDSCALE;
            dac_imag_o <= MIDSCALE;
            stuff_ph <= 1'b0;
            out_is_stuff <= 1'b1;
         end else if (buf_valid) begin
            dac_valid_o <= 1'b1;
            dac_real_o <= to_dac(buf_data[2*SAMPLE_W-1:SAMPLE_W]);
            dac_imag_o <= to_dac(buf_data[SAMPLE_W-1:0]);
            stuff_ph <= stuff_en;
            out_is_stuff <= 1'b0;
         end else begin
            dac_valid_o <= 1'b0;
            out_is_stuff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_stuff_midscale: assert property (
      (dac_valid_o && out_is_stuff) |-> (dac_real_o == MIDSCALE && dac_imag_o == MIDSCALE))
      else $error("stuffed slot is not midscale");

   chk_stuff_alternate: assert property (
      (out_adv && !stuff_ph && buf_valid && stuff_en)
      |=> (dac_valid_o && !out_is_stuff && stuff_ph)
      ##1 (!$past(out_adv) || (dac_valid_o && out_is_stuff)))
      else $error("data slot not followed by midscale");

   chk_stuff_off: assert property (
      (out_adv && !stuff_en && !stuff_ph) |=> !out_is_stuff)
      else $error("midscale inserted while stuffing is off");

   chk_ratio_double: assert property (
      stuff_en |-> (clk_ratio_o == (RATIO_W'(2) << ctrl[INTERP_LSB+:2])))
      else $error("clock ratio not doubled by stuffing");

   chk_half_step: assert property (
      (smp_fire && rate == MOD_HALF && !ctrl_wr) |=> (phase == $past(phase) + 3'h4))
      else $error("half rate carrier did not alternate");

   chk_quarter_zero: assert property (
      (smp_fire && !cplx_active && rate == MOD_QUARTER && !phase[1])
      |=> (mod_valid && mod_re == '0 && mod_im == '0))
      else $error("quarter rate zero slot not zero");

   chk_cplx_half: assert property (
      (cplx_req && rate == MOD_HALF) |-> (!cplx_active && status_word[ST_REFUSE_BIT]))
      else $error("complex mix running at half rate");

   chk_sat_limit: assert property (
      (smp_fire && !sh_re[SW-1] && sh_re[SW-2:SAMPLE_W-1] != '0)
      |=> (mod_re == {1'b0, {(SAMPLE_W - 1){1'b1}}}))
      else $error("real result wrapped instead of saturating");

endmodule

// File: zero_stuff_complex_modulator_bench.sv
// self-checking bench: register bus, modulation table, stuffing, stall.
// assumes the partner source model and the design package.
`timescale 1ns/10ps
module zero_stuff_complex_modulator_bench import modulator_pkg::*;;
   logic mclk_i = 0, rst_n_i = 0, ce_i = 1, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
   logic arvalid_i = 0, rready_i = 0, dac_ready_i = 1, go = 0, ta, tw, tr, awready_o;
   logic wready_o, bvalid_o, arready_o, rvalid_o, smp_valid_i, smp_ready_o, dac_valid_o;
   logic [ADDR_W-1:0] awaddr_i = 0, araddr_i = 0;
   logic [31:0] wdata_i = 0, rdata_o, d;
   logic [3:0] wstrb_i = 4'h1;
   logic [1:0] bresp_o, rresp_o, rs, interp_sel_o;
   logic [4:0] clk_ratio_o;
   logic [15:0] smp_i_i, smp_q_i, dac_real_o, dac_imag_o, iset = 0, qset = 0, re, im;
   int n_fail = 0, checked = 0, taken, t0, n, r, j;
   // rows: control, i, q, first re/im, second re/im (offset binary), clock ratio
   logic [15:0] rw [10][8] = '{
      '{16'h0000, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h9000, 16'h8800, 16'h0001},
      '{16'h0050, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h7000, 16'h7800, 16'h0002},
      '{16'h00A0, 16'h1000, 16'h0800, 16'h8000, 16'h8000, 16'h9000, 16'h8800, 16'h0004},
      '{16'h0024, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h7800, 16'h9000, 16'h0001},
      '{16'h0026, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h8800, 16'h7000, 16'h0001},
      '{16'h0014, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h7000, 16'h7800, 16'h0001},
      '{16'h0034, 16'h1000, 16'h0000, 16'h9000, 16'h8000, 16'h8B50, 16'h8B50, 16'h0001},
      '{16'h002C, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h7800, 16'h9000, 16'h0002},
      '{16'h00EC, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0010},
      '{16'h00C0, 16'h1000, 16'h0800, 16'h9000, 16'h8800, 16'h9000, 16'h8800, 16'h0008}};
   zero_stuff_complex_modulator dut (.mclk_i, .rst_n_i, .ce_i, .awaddr_i, .awvalid_i,
      .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
      .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
      .smp_valid_i, .smp_ready_o, .smp_i_i, .smp_q_i, .dac_valid_o, .dac_ready_i,
      .dac_real_o, .dac_imag_o, .interp_sel_o, .clk_ratio_o);
   sample_source src (.mclk_i, .rst_n_i, .go_i(go), .i_set_i(iset), .q_set_i(qset),
      .ready_i(smp_ready_o), .valid_o(smp_valid_i), .i_o(smp_i_i), .q_o(smp_q_i),
      .taken_o(taken));
   always #2 mclk_i = ~mclk_i;
   task give_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // compare one result, four-state exact
   task chk(input logic [35:0] g, input logic [35:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   // one axi4-lite write or read; handshakes judged at the settled negedge
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] v,
            output logic [31:0] q, output logic [1:0] rp);
      int k;
      awaddr_i <= a;
      araddr_i <= a;
      wdata_i <= v;
      awvalid_i <= wr;
      wvalid_i <= wr;
      bready_i <= wr;
      arvalid_i <= !wr;
      rready_i <= !wr;
      for (k = 0; k < 50; k++) begin
         @(negedge mclk_i);
         if (bvalid_o || rvalid_o) break;
         ta = awvalid_i && awready_o;
         tw = wvalid_i && wready_o;
         tr = arvalid_i && arready_o;
         @(posedge mclk_i);
         if (ta) awvalid_i <= 1'b0;
         if (tw) wvalid_i <= 1'b0;
         if (tr) arvalid_i <= 1'b0;
      end
      if (k == 50) begin
         n_fail++;
         give_verdict();
      end
      q = rdata_o;
      rp = wr ? bresp_o : rresp_o;
      @(posedge mclk_i);
      bready_i <= 1'b0;
      rready_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // take one dac word
   task get;
      int k;
      for (k = 0; k < 50; k++) begin
         @(negedge mclk_i);
         if (dac_valid_o && dac_ready_i) break;
      end
      if (k == 50) begin
         n_fail++;
         give_verdict();
      end
      re = dac_real_o;
      im = dac_imag_o;
      @(posedge mclk_i);
   endtask
   // let the pipeline empty, counting the words that leave
   task drain;
      n = 0;
      repeat (30) begin
         @(negedge mclk_i);
         if (dac_valid_o && dac_ready_i) n++;
      end
      @(posedge mclk_i);
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(negedge mclk_i);
      chk({dac_real_o, clk_ratio_o}, {16'h8000, 5'h01});
      @(posedge mclk_i);
      bus(0, CTRL_ADDR, 0, d, rs);
      chk(d, CTRL_RESET);
      wstrb_i <= 4'h0;
      bus(1, CTRL_ADDR, 32'h0000_00FF, d, rs);
      chk(rs, RESP_OKAY);
      wstrb_i <= 4'h1;
      bus(0, CTRL_ADDR, 0, d, rs);
      chk(d, CTRL_RESET);
      bus(1, 12'h010, 1, d, rs);
      chk(rs, RESP_SLVERR);
      bus(1, STATUS_ADDR, 1, d, rs);
      chk(rs, RESP_SLVERR);
      bus(0, 12'h010, 0, d, rs);
      chk({d, rs}, {32'h0000_0000, RESP_SLVERR});
      $display("map test done");
      // table of modes; stuffed words must sit between data words
      for (r = 0; r < 10; r++) begin
         go <= 1'b0;
         drain();
         iset <= rw[r][1];
         qset <= rw[r][2];
         bus(1, CTRL_ADDR, {16'h0000, rw[r][0]}, d, rs);
         bus(0, CTRL_ADDR, 0, d, rs);
         chk(d, rw[r][0]);
         chk({interp_sel_o, clk_ratio_o}, {rw[r][0][7:6], rw[r][7][4:0]});
         bus(0, STATUS_ADDR, 0, d, rs);
         chk(d, {22'h0, rw[r][0][2] && rw[r][0][5:4] == 2'b01,
            rw[r][0][2] && rw[r][0][5:4] != 2'b01, 3'h0, rw[r][7][4:0]});
         go <= 1'b1;
         for (j = 0; j < 2; j++) begin
            get();
            chk({re, im}, {rw[r][3+2*j], rw[r][4+2*j]});
            if (rw[r][0][3] && j == 0) get();
            if (rw[r][0][3] && j == 0) chk({re, im}, 32'h8000_8000);
         end
         $display("row %0d done", r);
      end
      // stall the dac side until the source is refused, then count every word
      go <= 1'b0;
      drain();
      t0 = taken;
      dac_ready_i <= 1'b0;
      go <= 1'b1;
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(smp_ready_o, 1'b0);
      @(posedge mclk_i);
      go <= 1'b0;
      dac_ready_i <= 1'b1;
      drain();
      chk(n, taken - t0);
      $display("stall test done");
      // enable low drops the sample and read readies, then a reset in mid-run
      ce_i <= 1'b0;
      @(negedge mclk_i);
      chk({smp_ready_o, arready_o}, 2'b00);
      @(posedge mclk_i);
      ce_i <= 1'b1;
      rst_n_i <= 1'b0;
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(negedge mclk_i);
      chk({interp_sel_o, clk_ratio_o, dac_valid_o}, {2'b00, 5'h01, 1'b0});
      $display("reset test done");
      give_verdict();
   end
endmodule
